// File: logic/usbdc_defines.svh
// usbdc_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the usb device core control design
`ifndef USBDC_DEFINES_SVH
`define USBDC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define USBDC_OFF_GENCTL   8'h00
`define USBDC_OFF_DEVCTL   8'h04
`define USBDC_OFF_DEVIFLG  8'h08
`define USBDC_OFF_DEVIEN   8'h0C
`define USBDC_OFF_EPSEL    8'h10
`define USBDC_OFF_EPCFG    8'h14
`define USBDC_OFF_EPIFLG   8'h18
`define USBDC_OFF_EPIEN    8'h1C
`define USBDC_OFF_EPSUM    8'h20
`define USBDC_OFF_DPADDR   8'h24
`define USBDC_OFF_DPDATA   8'h28
`define USBDC_OFF_LINEDRV  8'h2C
`define USBDC_OFF_EPBASE   8'h30

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define USBDC_GEN_ENABLE   7
`define USBDC_GEN_FREEZE   5
`define USBDC_DEV_DETACH   0
`define USBDC_DEV_EORRST   1
`define USBDC_DIF_SUSP     0
`define USBDC_DIF_WAKE     1
`define USBDC_DIF_EOR      2
`define USBDC_EPC_ENABLE   0
`define USBDC_EPC_RESERVE  1
`define USBDC_EPC_CONFIG_ACCEPTED_FLAG    7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define USBDC_GEN_RESET    8'h20
`define USBDC_DEV_RESET    8'h01

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define USBDC_CLK_HZ       10000000
`define USBDC_SUSP_US      3000
`define USBDC_SUSP_CYC     ((`USBDC_SUSP_US * (`USBDC_CLK_HZ / 1000)) / 1000)
`define USBDC_EOR_US       100
`define USBDC_EOR_CYC      ((`USBDC_EOR_US * (`USBDC_CLK_HZ / 1000)) / 1000)
`define USBDC_DPRAM_BYTES  176

`endif

// File: logic/usbdc_pkg.sv
// usbdc_pkg.sv: types shared by the usb device core control design
// assumes: compiled before the design module
package usbdc_pkg;
	typedef enum logic [1:0] {
		USBDC_PAD_IDLE,
		USBDC_PAD_ACTIVE
	} usbdc_pad_t;

	typedef enum logic [1:0] {
		USBDC_LS_J,
		USBDC_LS_K,
		USBDC_LS_SE0,
		USBDC_LS_SE1
	} usbdc_line_t;
endpackage : usbdc_pkg

// File: logic/usbdc_core.sv
// usbdc_core.sv: general control of a full-speed usb device controller
// assumes: wishbone classic master on core_clk_i, line pins asynchronous
//
// Summary of operation
// - 48 MHz reference, recovered 12 MHz bit clock
// - any hardware reset disables and resets controller
// - end-of-reset source resets but keeps enabled
// - timed interrupts only unfrozen; wake on line change
// - power-down wakes only through wake interrupt
// - eight enabled sources per endpoint, one vector
// - summary register names interrupting endpoints
// - any usb interrupt wakes idle cpu
// - listed registers stay accessible while frozen
// - frozen controller raises only wake interrupt
// - 176-byte memory serves five endpoints
// - reserve inserts region, next higher slides up
// - clearing enable keeps reserve and configuration
// - freeing reserve slides next higher region down
// - endpoint 0 data survives higher endpoint changes
// - identical re-reserve moves no higher region
// - config-accepted set even on overlap
// - suspend idles pad; activity wakes pad
// - detach idles pad; clearing reactivates
// - line writes only when enabled; reads always
// - enable bit enables; clear resets; reserved zero
// - 3 ms idle J sets suspend flag
`timescale 1ns/1ns
`default_nettype none
`include "usbdc_defines.svh"

module usbdc_core #(
	parameter int unsigned NUM_EP    = 5,
	parameter int unsigned SUSP_CYC  = `USBDC_SUSP_CYC,
	parameter int unsigned EOR_CYC   = `USBDC_EOR_CYC
) (
	// clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        clk_en_i,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// endpoint event sources from the transfer engine
	input  wire logic [39:0] ep_event_i,
	// usb line, two-way pins
	input  wire logic        dp_i,
	input  wire logic        dm_i,
	output logic             dp_o,
	output logic             dm_o,
	output logic             dp_oe_o,
	output logic             dm_oe_o,
	// status towards the chip
	output logic             ctrl_enabled_o,
	output logic             ctrl_reset_o,
	output logic             usb_clk_run_o,
	output logic             pad_active_o,
	output logic             pullup_en_o,
	output logic             gen_irq_o,
	output logic             ep_irq_o,
	output logic             wake_irq_o,
	output logic             cpu_wake_o
);
	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0]              dp_sync;
		logic [1:0]              dm_sync;
		logic [1:0]              line_prev;
		logic                    enable;
		logic                    freeze;
		logic                    detach;
		logic                    eor_sel;
		logic [2:0]              dflag;
		logic [2:0]              dien;
		logic [2:0]              epsel;
		logic [NUM_EP-1:0]       ep_en;
		logic [NUM_EP-1:0]       ep_res;
		logic [NUM_EP-1:0]       ep_ok;
		logic [NUM_EP-1:0][2:0]  ep_size;
		logic [NUM_EP-1:0]       ep_bank;
		logic [NUM_EP-1:0][7:0]  ep_base;
		logic [NUM_EP-1:0][7:0]  ep_flg;
		logic [NUM_EP-1:0][7:0]  ep_ien;
		logic [7:0]              dpaddr;
		logic [3:0]              drive;
		logic [15:0]             idle_cnt;
		logic [15:0]             se0_cnt;
		usbdc_pkg::usbdc_pad_t   pad;
		logic                    ack;
		logic [31:0]             rdata;
	} usbdc_state_t;

	usbdc_state_t st_q;
	usbdc_state_t st_d;
	logic [7:0]   dpram [0:`USBDC_DPRAM_BYTES-1];

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// bytes taken by an endpoint: 8 << size, size capped at 3, doubled with two banks
	function automatic logic [7:0] usbdc_ep_bytes(input logic [2:0] sz,
		input logic bk);
		logic [7:0] b;
		b = 8'h08 << ((sz > 3'h3) ? 3'h3 : sz);
		usbdc_ep_bytes = bk ? 8'(b << 1) : b;
	endfunction : usbdc_ep_bytes

	function automatic logic [31:0] usbdc_byte(input logic [7:0] v);
		usbdc_byte = {24'h0, v};
	endfunction : usbdc_byte

	// ------------------------------------------------------------------------
	// combinational next state
	// ------------------------------------------------------------------------
	logic                  wr;
	logic                  rd;
	logic                  frozen;
	logic                  timed_ok;
	logic [1:0]            line;
	logic                  eor_evt;
	logic [NUM_EP-1:0]     ep_pend;
	logic [7:0]            wbyte;
	logic [2:0]            sel;
	logic [7:0]            nb;
	logic [7:0]            top;
	logic                  dp_wr;
	logic                  chg;

	assign line     = {st_q.dp_sync[1], st_q.dm_sync[1]};
	assign frozen   = st_q.freeze | ~st_q.enable;
	assign timed_ok = ~frozen;
	assign wbyte    = wb_dat_i[7:0];
	assign sel      = st_q.epsel;

	always_comb begin
		st_d  = st_q;
		wr    = 1'b0;
		rd    = 1'b0;
		eor_evt = 1'b0;
		nb    = 8'h00;
		top   = 8'h00;
		dp_wr = 1'b0;
		chg   = 1'b0;
		for (int i = 0; i < NUM_EP; i++) begin
			ep_pend[i] = |(st_q.ep_flg[i] & st_q.ep_ien[i]);
		end
		// line sampled through two flops, second one read only
		st_d.dp_sync   = {st_q.dp_sync[0], dp_i};
		st_d.dm_sync   = {st_q.dm_sync[0], dm_i};
		st_d.line_prev = line;
		st_d.ack       = 1'b0;
		// register access, one wait state; frozen clock does not block it
		if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
			st_d.ack = 1'b1;
			wr = wb_we_i & wb_sel_i[0];
			rd = ~wb_we_i;
		end
		st_d.rdata = 32'h0;
		if (rd) begin
			case (wb_adr_i)
				`USBDC_OFF_GENCTL:  st_d.rdata = usbdc_byte({st_q.enable,
					1'b0, st_q.freeze, 5'h00});
				`USBDC_OFF_DEVCTL:  st_d.rdata = usbdc_byte({6'h00,
					st_q.eor_sel, st_q.detach});
				`USBDC_OFF_DEVIFLG: st_d.rdata = usbdc_byte({5'h00, st_q.dflag});
				`USBDC_OFF_DEVIEN:  st_d.rdata = usbdc_byte({5'h00, st_q.dien});
				`USBDC_OFF_EPSEL:   st_d.rdata = usbdc_byte({5'h00, sel});
				`USBDC_OFF_EPCFG:   st_d.rdata = usbdc_byte({st_q.ep_ok[sel],
					1'b0, st_q.ep_bank[sel], st_q.ep_size[sel],
					st_q.ep_res[sel], st_q.ep_en[sel]});
				`USBDC_OFF_EPIFLG:  st_d.rdata = usbdc_byte(st_q.ep_flg[sel]);
				`USBDC_OFF_EPIEN:   st_d.rdata = usbdc_byte(st_q.ep_ien[sel]);
				`USBDC_OFF_EPSUM:   st_d.rdata = usbdc_byte(8'(ep_pend));
				`USBDC_OFF_DPADDR:  st_d.rdata = usbdc_byte(st_q.dpaddr);
				`USBDC_OFF_DPDATA:  st_d.rdata = usbdc_byte(dpram[st_q.dpaddr]);
				`USBDC_OFF_LINEDRV: st_d.rdata = usbdc_byte({st_q.drive,
					2'h0, line});
				`USBDC_OFF_EPBASE:  st_d.rdata = usbdc_byte(st_q.ep_base[sel]);
				default:            st_d.rdata = 32'h0;
			endcase
		end
		if (wr) begin
			case (wb_adr_i)
				`USBDC_OFF_GENCTL: begin
					st_d.enable = wbyte[`USBDC_GEN_ENABLE];
					st_d.freeze = wbyte[`USBDC_GEN_FREEZE];
				end
				`USBDC_OFF_DEVCTL: begin
					st_d.detach  = wbyte[`USBDC_DEV_DETACH];
					st_d.eor_sel = wbyte[`USBDC_DEV_EORRST];
				end
				`USBDC_OFF_DEVIFLG: st_d.dflag = st_q.dflag & wbyte[2:0];
				`USBDC_OFF_DEVIEN:  st_d.dien  = wbyte[2:0];
				`USBDC_OFF_EPSEL:   st_d.epsel = wbyte[2:0];
				`USBDC_OFF_EPCFG: if (32'(sel) < NUM_EP) begin
					// enable clear keeps reserve, size and bank
					st_d.ep_en[sel]   = wbyte[`USBDC_EPC_ENABLE];
					st_d.ep_res[sel]  = wbyte[`USBDC_EPC_RESERVE];
					st_d.ep_size[sel] = wbyte[4:2];
					st_d.ep_bank[sel] = wbyte[5];
					nb = usbdc_ep_bytes(wbyte[4:2], wbyte[5]);
					// same region rewritten must not disturb neighbours
					chg = (wbyte[`USBDC_EPC_RESERVE] != st_q.ep_res[sel]) ||
						(wbyte[`USBDC_EPC_RESERVE] && nb != usbdc_ep_bytes(
						st_q.ep_size[sel], st_q.ep_bank[sel]));
					// region starts after the lower neighbour
					if (sel != 3'h0)
						top = 8'(st_q.ep_base[sel-1] + (st_q.ep_res[sel-1] ?
							usbdc_ep_bytes(st_q.ep_size[sel-1],
							st_q.ep_bank[sel-1]) : 8'h00));
					st_d.ep_base[sel] = top;
					// only the next higher region slides, others stay
					if (32'(sel) + 1 < NUM_EP && st_q.ep_res[sel+1] &&
						chg) begin
						if (wbyte[`USBDC_EPC_RESERVE])
							st_d.ep_base[sel+1] = 8'(top + nb);
						else
							st_d.ep_base[sel+1] = top;
					end
					// accepted even on overlap; refused when too big or reserve clear
					st_d.ep_ok[sel] = wbyte[`USBDC_EPC_RESERVE] &&
						(9'(top) + 9'(nb) <= 9'(`USBDC_DPRAM_BYTES));
				end
				`USBDC_OFF_EPIFLG: st_d.ep_flg[sel] = st_q.ep_flg[sel] & wbyte;
				`USBDC_OFF_EPIEN:  st_d.ep_ien[sel] = wbyte;
				`USBDC_OFF_DPADDR: st_d.dpaddr = wbyte;
				`USBDC_OFF_DPDATA: dp_wr = 1'b1;
				`USBDC_OFF_LINEDRV: if (st_q.enable)
					st_d.drive = wbyte[7:4];
				default: ;
			endcase
		end
		// endpoint events; set wins over software clear
		if (timed_ok) begin
			for (int i = 0; i < NUM_EP; i++) begin
				if (st_q.ep_en[i])
					st_d.ep_flg[i] = st_d.ep_flg[i] | ep_event_i[i*8 +: 8];
			end
		end
		// suspend timer on idle J
		if (timed_ok && line == 2'b10) begin
			if (st_q.idle_cnt >= 16'(SUSP_CYC - 1)) begin
				if (st_q.idle_cnt == 16'(SUSP_CYC - 1)) begin
					st_d.dflag[`USBDC_DIF_SUSP] = 1'b1;
					st_d.pad = usbdc_pkg::USBDC_PAD_IDLE;
				end
				st_d.idle_cnt = 16'(SUSP_CYC);
			end else
				st_d.idle_cnt = st_q.idle_cnt + 16'h1;
		end else
			st_d.idle_cnt = 16'h0;
		// bus reset: long se0, end of it at release
		if (timed_ok && line == 2'b00) begin
			if (st_q.se0_cnt < 16'(EOR_CYC))
				st_d.se0_cnt = st_q.se0_cnt + 16'h1;
		end else begin
			if (st_q.se0_cnt == 16'(EOR_CYC))
				eor_evt = 1'b1;
			st_d.se0_cnt = 16'h0;
		end
		// line change is seen even while frozen
		if (line != st_q.line_prev && st_q.enable) begin
			st_d.dflag[`USBDC_DIF_WAKE] = 1'b1;
			st_d.pad = usbdc_pkg::USBDC_PAD_ACTIVE;
		end
		if (st_d.detach)
			st_d.pad = usbdc_pkg::USBDC_PAD_IDLE;
		else if (st_q.detach)
			st_d.pad = usbdc_pkg::USBDC_PAD_ACTIVE;
		if (eor_evt) begin
			st_d.dflag[`USBDC_DIF_EOR] = 1'b1;
			// endpoints disabled, control endpoint stays configured
			st_d.ep_en[NUM_EP-1:1] = '0;
			if (st_q.eor_sel) begin
				// reset without disabling keeps the device attached
				st_d.dflag = 3'(1 << `USBDC_DIF_EOR);
				st_d.drive = 4'h0;
			end
		end
		// disable clears flags, endpoint enable/reserve/accepted, drive, timers and pad
		if (!st_d.enable) begin
			st_d.dflag    = 3'h0;
			st_d.ep_en    = '0;
			st_d.ep_res   = '0;
			st_d.ep_ok    = '0;
			st_d.ep_flg   = '0;
			st_d.drive    = 4'h0;
			st_d.idle_cnt = 16'h0;
			st_d.se0_cnt  = 16'h0;
			st_d.pad      = usbdc_pkg::USBDC_PAD_IDLE;
		end
	end

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_q        <= '0;
			st_q.freeze <= 1'(`USBDC_GEN_RESET >> `USBDC_GEN_FREEZE);
			st_q.detach <= 1'b1;
			st_q.pad    <= usbdc_pkg::USBDC_PAD_IDLE;
		end else if (clk_en_i) begin
			st_q <= st_d;
		end
	end

	// endpoint 0 sits at base zero and never slides, so its data stays
	always_ff @(posedge core_clk_i) begin
		if (clk_en_i && dp_wr)
			dpram[st_q.dpaddr] <= wbyte;
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign wb_ack_o       = st_q.ack;
	assign wb_dat_o       = st_q.rdata;
	assign dp_o           = st_q.drive[1];
	assign dm_o           = st_q.drive[0];
	assign dp_oe_o        = st_q.enable & st_q.drive[3];
	assign dm_oe_o        = st_q.enable & st_q.drive[3];
	assign ctrl_enabled_o = st_q.enable;
	assign ctrl_reset_o   = ~st_q.enable;
	// 48 MHz reference and bit-clock recovery gate on this
	assign usb_clk_run_o  = st_q.enable & ~st_q.freeze;
	assign pad_active_o   = st_q.pad == usbdc_pkg::USBDC_PAD_ACTIVE;
	assign pullup_en_o    = st_q.enable & ~st_q.detach;
	assign gen_irq_o      = |(st_q.dflag & st_q.dien &
		{~frozen, 1'b1, ~frozen});
	assign ep_irq_o       = timed_ok & |ep_pend;
	assign wake_irq_o     = st_q.dflag[`USBDC_DIF_WAKE] &
		st_q.dien[`USBDC_DIF_WAKE];
	assign cpu_wake_o     = gen_irq_o | ep_irq_o;
endmodule : usbdc_core
`default_nettype wire

// File: verification/usbdc_host_model.sv
// usbdc_host_model.sv: host end of the usb line
// assumes: bench picks the line state, device drive wins
`timescale 1ns/1ns
`default_nettype none
module usbdc_host_model (
	// wanted line state
	input  wire usbdc_pkg::usbdc_line_t host_ls_i,
	// device pin side
	input  wire logic                   dev_dp_i,
	input  wire logic                   dev_dm_i,
	input  wire logic                   dev_dp_oe_i,
	input  wire logic                   dev_dm_oe_i,
	// resolved levels
	output logic                        dp_lvl_o,
	output logic                        dm_lvl_o
);
	logic host_dp;
	logic host_dm;

	// no float: the host always drives a defined state
	assign host_dp  = host_ls_i inside {usbdc_pkg::USBDC_LS_J,
		usbdc_pkg::USBDC_LS_SE1};
	assign host_dm  = host_ls_i inside {usbdc_pkg::USBDC_LS_K,
		usbdc_pkg::USBDC_LS_SE1};
	assign dp_lvl_o = dev_dp_oe_i ? dev_dp_i : host_dp;
	assign dm_lvl_o = dev_dm_oe_i ? dev_dm_i : host_dm;
endmodule : usbdc_host_model
`default_nettype wire

// File: verification/usbdc_core_asserts.sv
// usbdc_core_asserts.sv: port checks for usbdc_core
// assumes: bound to usbdc_core, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module usbdc_core_asserts (
	// clock and bus
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// pins and status
	input wire logic dp_oe_o,
	input wire logic dm_oe_o,
	input wire logic ctrl_enabled_o,
	input wire logic usb_clk_run_o,
	input wire logic pad_active_o,
	input wire logic pullup_en_o,
	input wire logic gen_irq_o,
	input wire logic ep_irq_o,
	input wire logic wake_irq_o,
	input wire logic cpu_wake_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence wb_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wb_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	AST_WB_ANSWER: assert property (wb_take |=> wb_pulse)
		else $error("bus request not answered by one ack");
	AST_RESET_STATE: assert property ($fell(reset_i) |->
		!ctrl_enabled_o && !usb_clk_run_o && !pullup_en_o)
		else $error("controller not disabled after reset");
	AST_CLK_RUN: assert property (usb_clk_run_o |-> ctrl_enabled_o)
		else $error("clock runs while disabled");
	AST_FROZEN_EP: assert property (
		!usb_clk_run_o [*2] |-> !ep_irq_o)
		else $error("endpoint interrupt while frozen");
	AST_FROZEN_GEN: assert property (
		!usb_clk_run_o [*2] |-> !gen_irq_o || wake_irq_o)
		else $error("timed interrupt while frozen");
	AST_CPU_WAKE: assert property (
		cpu_wake_o == (gen_irq_o || ep_irq_o))
		else $error("cpu wake does not follow interrupts");
	AST_DRIVE_OFF: assert property (
		!ctrl_enabled_o [*2] |-> !dp_oe_o && !dm_oe_o)
		else $error("line driven while disabled");
	AST_DETACH_IDLE: assert property (
		(ctrl_enabled_o && !pullup_en_o) [*2] |-> !pad_active_o)
		else $error("pad active while detached");
endmodule : usbdc_core_asserts

bind usbdc_core usbdc_core_asserts usbdc_core_asserts_inst (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dp_oe_o(dp_oe_o),
	.dm_oe_o(dm_oe_o), .ctrl_enabled_o(ctrl_enabled_o),
	.usb_clk_run_o(usb_clk_run_o), .pad_active_o(pad_active_o),
	.pullup_en_o(pullup_en_o), .gen_irq_o(gen_irq_o),
	.ep_irq_o(ep_irq_o), .wake_irq_o(wake_irq_o), .cpu_wake_o(cpu_wake_o));
`default_nettype wire

// File: verification/test_usbdc_core.sv
// test_usbdc_core.sv: register-level bench for usbdc_core
// assumes: host model on the line, checker bound by its own file
`timescale 1ns/1ns
`default_nettype none
module test_usbdc_core;
	logic                   core_clk_i;
	logic                   reset_i;
	logic                   cyc;
	logic                   we;
	logic [7:0]             adr;
	logic [31:0]            wdat;
	logic [39:0]            ev;
	int                     num_errors;
	int                     checks;
	usbdc_pkg::usbdc_line_t host_ls;
	wire logic [31:0]       wb_dat_o;
	wire logic              wb_ack_o, dp_o, dm_o, dp_oe_o, dm_oe_o;
	wire logic              dp_l, dm_l, ctrl_enabled_o, ctrl_reset_o;
	wire logic              usb_clk_run_o, pad_active_o, pullup_en_o;
	wire logic              gen_irq_o, ep_irq_o, wake_irq_o, cpu_wake_o;

	// short suspend and bus-reset counts keep the run brief
	usbdc_core #(.SUSP_CYC(20), .EOR_CYC(5)) usbdc_core_inst (
		.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'h1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ep_event_i(ev), .dp_i(dp_l), .dm_i(dm_l),
		.dp_o(dp_o), .dm_o(dm_o), .dp_oe_o(dp_oe_o), .dm_oe_o(dm_oe_o),
		.ctrl_enabled_o(ctrl_enabled_o), .ctrl_reset_o(ctrl_reset_o),
		.usb_clk_run_o(usb_clk_run_o), .pad_active_o(pad_active_o),
		.pullup_en_o(pullup_en_o), .gen_irq_o(gen_irq_o),
		.ep_irq_o(ep_irq_o), .wake_irq_o(wake_irq_o),
		.cpu_wake_o(cpu_wake_o));

	usbdc_host_model usbdc_host_model_inst (
		.host_ls_i(host_ls), .dev_dp_i(dp_o), .dev_dm_i(dm_o),
		.dev_dp_oe_i(dp_oe_o), .dev_dm_oe_i(dm_oe_o),
		.dp_lvl_o(dp_l), .dm_lvl_o(dm_l));

	initial begin
		core_clk_i = 1'h0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	task automatic close_out;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one classic cycle; a dead slave is left to the watchdog
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge core_clk_i);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o[7:0];
		cyc <= 1'h0;
		@(posedge core_clk_i);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] q;
		bus(1'h0, a, 8'h00, q);
		check(q & m, e);
	endtask : rd

	task automatic epc(input logic [7:0] i, input logic [7:0] c);
		wr(8'h10, i);
		wr(8'h14, c);
	endtask : epc

	task automatic base(input logic [7:0] i, input logic [7:0] e);
		wr(8'h10, i);
		rd(8'h30, 8'hFF, e);
	endtask : base

	task automatic pulse(input logic [39:0] e);
		ev <= e;
		@(posedge core_clk_i);
		ev <= 40'h0;
		repeat (2) @(posedge core_clk_i);
	endtask : pulse

	initial begin
		repeat (3000) @(posedge core_clk_i);
		num_errors++;
		close_out();
	end

	initial begin
		reset_i = 1'h1;
		cyc = 1'h0;
		we = 1'h0;
		adr = 8'h00;
		wdat = 32'h0;
		ev = 40'h0;
		host_ls = usbdc_pkg::USBDC_LS_J;
		num_errors = 0;
		checks = 0;
		repeat (16) @(posedge core_clk_i);
		reset_i <= 1'h0;
		rd(8'h00, 8'hFF, 8'h20);
		rd(8'h04, 8'hFF, 8'h01);
		check({6'h0, ctrl_reset_o, pullup_en_o}, 8'h02);
		wr(8'h2C, 8'hA0);
		check({6'h0, dp_oe_o, dm_oe_o}, 8'h00);
		rd(8'h2C, 8'hFF, 8'h02);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'hFF, 8'hA0);
		wr(8'h04, 8'h02);
		rd(8'h04, 8'hFF, 8'h02);
		wr(8'h0C, 8'h03);
		rd(8'h0C, 8'hFF, 8'h03);
		wr(8'h24, 8'h5A);
		rd(8'h24, 8'hFF, 8'h5A);
		wr(8'h28, 8'hC3);
		rd(8'h28, 8'hFF, 8'hC3);
		repeat (40) @(posedge core_clk_i);
		rd(8'h08, 8'h01, 8'h00);
		host_ls <= usbdc_pkg::USBDC_LS_K;
		repeat (6) @(posedge core_clk_i);
		rd(8'h08, 8'h02, 8'h02);
		check({7'h0, wake_irq_o}, 8'h01);
		host_ls <= usbdc_pkg::USBDC_LS_J;
		repeat (4) @(posedge core_clk_i);
		wr(8'h00, 8'h80);
		check({7'h0, usb_clk_run_o}, 8'h01);
		wr(8'h08, 8'h00);
		repeat (30) @(posedge core_clk_i);
		rd(8'h08, 8'h01, 8'h01);
		check({6'h0, pad_active_o, gen_irq_o}, 8'h01);
		host_ls <= usbdc_pkg::USBDC_LS_K;
		repeat (6) @(posedge core_clk_i);
		rd(8'h08, 8'h02, 8'h02);
		check({7'h0, pad_active_o}, 8'h01);
		wr(8'h04, 8'h03);
		repeat (2) @(posedge core_clk_i);
		check({7'h0, pad_active_o}, 8'h00);
		wr(8'h04, 8'h02);
		repeat (2) @(posedge core_clk_i);
		check({7'h0, pad_active_o}, 8'h01);
		wr(8'h2C, 8'hA0);
		repeat (2) @(posedge core_clk_i);
		check({5'h0, dp_oe_o, dp_o, dm_o}, 8'h06);
		wr(8'h2C, 8'h00);
		// four 8-byte endpoints, lowest first
		for (int i = 0; i < 4; i++)
			epc(8'(i), 8'h03);
		base(8'h02, 8'h10);
		base(8'h03, 8'h18);
		epc(8'h01, 8'h01);
		base(8'h02, 8'h08);
		base(8'h03, 8'h18);
		epc(8'h01, 8'h07);
		rd(8'h14, 8'h80, 8'h80);
		base(8'h02, 8'h18);
		base(8'h03, 8'h18);
		epc(8'h02, 8'h02);
		rd(8'h14, 8'h3F, 8'h02);
		epc(8'h02, 8'h03);
		base(8'h03, 8'h18);
		wr(8'h10, 8'h02);
		wr(8'h1C, 8'h08);
		pulse(40'h0000080000);
		rd(8'h18, 8'hFF, 8'h08);
		rd(8'h20, 8'h1F, 8'h04);
		check({7'h0, ep_irq_o}, 8'h01);
		check({7'h0, cpu_wake_o}, 8'h01);
		wr(8'h18, 8'h00);
		pulse(40'h0000100000);
		rd(8'h18, 8'hFF, 8'h10);
		check({7'h0, ep_irq_o}, 8'h00);
		host_ls <= usbdc_pkg::USBDC_LS_SE0;
		repeat (12) @(posedge core_clk_i);
		host_ls <= usbdc_pkg::USBDC_LS_J;
		repeat (4) @(posedge core_clk_i);
		check({7'h0, ctrl_enabled_o}, 8'h01);
		rd(8'h08, 8'h04, 8'h04);
		close_out();
	end
endmodule : test_usbdc_core
`default_nettype wire
